//--- rtl/lsup_pkg.sv
// shared constants, register map and carrier types of the link loss supervisor
// assumes a 100 MHz aclk and an AXI4-Lite master with 32-bit data
package lsup_pkg;

    // ************************************************
    // register map (byte addresses)
    // ************************************************
    localparam logic [7:0] LSUP_CTRL_OFF = 8'h00;
    localparam logic [7:0] LSUP_TMO_OFF = 8'h04;
    localparam logic [7:0] LSUP_SCALE_OFF = 8'h08;
    localparam logic [7:0] LSUP_SAFE_OFF = 8'h0C;
    localparam logic [7:0] LSUP_STAT_OFF = 8'h10;
    localparam logic [7:0] LSUP_MASK_OFF = 8'h14;
    localparam logic [7:0] LSUP_STATE_OFF = 8'h18;

    // ************************************************
    // field positions
    // ************************************************
    localparam int LSUP_CTRL_MODE_LSB = 0;
    localparam int LSUP_CTRL_ACT_LSB = 2;
    localparam int LSUP_CTRL_SPEED_BIT = 4;
    localparam int LSUP_CTRL_PROF_BIT = 5;
    localparam int LSUP_CTRL_REFRESH_BIT = 8;
    localparam int LSUP_CTRL_FRESET_BIT = 9;
    localparam int LSUP_STAT_LOSS_BIT = 0;
    localparam int LSUP_STAT_REFRESH_BIT = 1;
    localparam int LSUP_STAT_W = 2;

    // ************************************************
    // reset values and bus answers
    // ************************************************
    localparam logic [15:0] LSUP_SCALE_RST = 16'h0001;
    localparam logic [15:0] LSUP_TMO_RST = 16'h000A;
    localparam logic [1:0] LSUP_RESP_OKAY = 2'h0;
    localparam logic [1:0] LSUP_RESP_SLVERR = 2'h2;

    // ************************************************
    // timing
    // ************************************************
    localparam int LSUP_CLK_PERIOD_NS = 10;
    localparam int LSUP_MS_NS = 1000000;
    localparam logic [23:0] LSUP_TMO_UNIT_MS = 24'h000064;
    localparam logic [3:0] LSUP_CYCLE_SLOW_MS = 4'hA;
    localparam logic [3:0] LSUP_CYCLE_FAST_MS = 4'h2;
    localparam int LSUP_AVG_WINDOW_MS = 10000;
    localparam int LSUP_AVG_DEPTH = 16;
    localparam int LSUP_AVG_SHIFT = 4;
    localparam logic [9:0] LSUP_AVG_SAMPLE_MS = 10'(LSUP_AVG_WINDOW_MS / LSUP_AVG_DEPTH);

    // ************************************************
    // modes and carriers
    // ************************************************
    typedef enum logic [1:0] {
        LSUP_MODE_OFF = 2'h0,
        LSUP_MODE_ANY = 2'h1,
        LSUP_MODE_CTRL = 2'h2
    } lsup_mode_t;

    typedef enum logic [1:0] {
        LSUP_ACT_NONE = 2'h0,
        LSUP_ACT_FAULT = 2'h1,
        LSUP_ACT_SAFE = 2'h2,
        LSUP_ACT_LAST = 2'h3
    } lsup_action_t;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] action;
        logic cycle_speed_select;
        logic short_word_profile;
        logic [15:0] timeout;
    } lsup_cfg_t;

    typedef struct packed {
        logic request;
        logic ctrl_write;
        logic [15:0] ref_word;
        logic [15:0] actual;
    } lsup_fb_t;

endpackage

//--- rtl/lsup_supervisor.sv
// link loss supervisor: timeout watch, loss actions, reference scaling, cycle tick
// assumes fieldbus strobes are one-cycle pulses synchronous to aclk
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module lsup_supervisor
    import lsup_pkg::*;
#(
    parameter int MS_CYCLES = LSUP_MS_NS / LSUP_CLK_PERIOD_NS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire lsup_fb_t fb,
    output logic [31:0] ref_scaled,
    output logic [31:0] act_scaled,
    output logic [31:0] speed_ref,
    output logic fault_trip,
    output logic loss_alarm,
    output logic link_loss_event,
    output logic cycle_tick,
    output logic irq
);

    // ************************************************
    // helpers
    // ************************************************
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic addr_mapped(input logic [7:0] addr);
        return (addr == LSUP_CTRL_OFF) || (addr == LSUP_TMO_OFF) ||
               (addr == LSUP_SCALE_OFF) || (addr == LSUP_SAFE_OFF) ||
               (addr == LSUP_STAT_OFF) || (addr == LSUP_MASK_OFF) ||
               (addr == LSUP_STATE_OFF);
    endfunction

    typedef enum logic [1:0] {
        SUP_OFF,
        SUP_WATCH,
        SUP_LOST
    } lsup_state_t;

    logic [31:0] ctrl_reg;
    logic [15:0] tmo_reg;
    logic [15:0] scale_reg;
    logic [31:0] safe_reg;
    logic [LSUP_STAT_W-1:0] status_reg;
    logic [LSUP_STAT_W-1:0] mask_reg;
    logic refresh_reg;
    lsup_cfg_t cfg_reg;
    logic aw_hold_reg;
    logic [7:0] aw_addr_reg;
    logic w_hold_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [16:0] ms_cnt_reg;
    logic ms_tick;
    logic [3:0] cyc_cnt_reg;
    logic cycle_tick_reg;
    lsup_state_t sup_state_reg;
    logic [23:0] silence_reg;
    logic [23:0] limit;
    logic restart;
    logic expiry;
    logic loss_event_reg;
    logic fault_reg;
    logic alarm_reg;
    logic [31:0] ref_reg;
    logic [31:0] act_reg;
    logic [31:0] speed_reg;
    logic [31:0] avg_hold_reg;
    logic [31:0] avg_ring [LSUP_AVG_DEPTH];
    logic [35:0] avg_sum_reg;
    logic [3:0] avg_idx_reg;
    logic [9:0] avg_ms_reg;
    logic [31:0] avg_now;
    logic do_write;
    logic ar_take;
    logic [31:0] rd_mux;
    logic [LSUP_STAT_W-1:0] events;
    logic [31:0] tmo_merge;
    logic [31:0] scale_merge;

    // ************************************************
    // axi4-lite slave
    // ************************************************
    // address and data are taken in either order; one write is answered at a time
    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready = !w_hold_reg && !bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
    assign ar_take = s_axi_arvalid && !rvalid_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_hold_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= LSUP_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= addr_mapped(aw_addr_reg) ? LSUP_RESP_OKAY : LSUP_RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_mux = 32'h00000000;
        case ({s_axi_araddr[7:2], 2'h0})
            LSUP_CTRL_OFF: rd_mux = {ctrl_reg[31:LSUP_CTRL_REFRESH_BIT+1], refresh_reg,
                                     ctrl_reg[LSUP_CTRL_REFRESH_BIT-1:0]};
            LSUP_TMO_OFF: rd_mux = {16'h0000, tmo_reg};
            LSUP_SCALE_OFF: rd_mux = {16'h0000, scale_reg};
            LSUP_SAFE_OFF: rd_mux = safe_reg;
            LSUP_STAT_OFF: rd_mux = {30'h00000000, status_reg};
            LSUP_MASK_OFF: rd_mux = {30'h00000000, mask_reg};
            LSUP_STATE_OFF: rd_mux = {27'h0000000, sup_state_reg == SUP_LOST,
                                      cfg_reg.cycle_speed_select, alarm_reg, fault_reg,
                                      cfg_reg.short_word_profile};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= LSUP_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= addr_mapped({s_axi_araddr[7:2], 2'h0}) ? LSUP_RESP_OKAY
                                                                 : LSUP_RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ************************************************
    // configuration registers
    // ************************************************
    assign tmo_merge = merge_bytes({16'h0000, tmo_reg}, w_data_reg, w_strb_reg);
    assign scale_merge = merge_bytes({16'h0000, scale_reg}, w_data_reg, w_strb_reg);

    // ctrl bits 9 and 8 are strobes: never stored, so bit 8 reads back as the pending refresh and bit 9 as zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= 32'h00000000;
            tmo_reg <= LSUP_TMO_RST;
            scale_reg <= LSUP_SCALE_RST;
            safe_reg <= 32'h00000000;
            mask_reg <= '0;
        end else if (do_write) begin
            case (aw_addr_reg)
                LSUP_CTRL_OFF: ctrl_reg <= merge_bytes(ctrl_reg, w_data_reg, w_strb_reg) &
                                           32'h0000003F;
                LSUP_TMO_OFF: tmo_reg <= tmo_merge[15:0];
                LSUP_SCALE_OFF: begin
                    // a zero factor would blank every reference; keep the old one
                    if (scale_merge[15:0] != 16'h0000) begin
                        scale_reg <= scale_merge[15:0];
                    end
                end
                LSUP_SAFE_OFF: safe_reg <= merge_bytes(safe_reg, w_data_reg, w_strb_reg);
                LSUP_MASK_OFF: mask_reg <= w_data_reg[LSUP_STAT_W-1:0];
                default: ;
            endcase
        end
    end

    // refresh copies pending settings into the active set one cycle after the write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            refresh_reg <= 1'b0;
            cfg_reg <= '{mode: LSUP_MODE_OFF, action: LSUP_ACT_NONE, cycle_speed_select: 1'b0,
                         short_word_profile: 1'b0, timeout: LSUP_TMO_RST};
        end else begin
            if (do_write && aw_addr_reg == LSUP_CTRL_OFF && w_strb_reg[1] &&
                w_data_reg[LSUP_CTRL_REFRESH_BIT]) begin
                refresh_reg <= 1'b1;
            end else if (refresh_reg) begin
                refresh_reg <= 1'b0;
            end
            if (refresh_reg) begin
                cfg_reg.mode <= ctrl_reg[LSUP_CTRL_MODE_LSB +: 2];
                cfg_reg.action <= ctrl_reg[LSUP_CTRL_ACT_LSB +: 2];
                cfg_reg.cycle_speed_select <= ctrl_reg[LSUP_CTRL_SPEED_BIT];
                cfg_reg.short_word_profile <= ctrl_reg[LSUP_CTRL_PROF_BIT];
                cfg_reg.timeout <= tmo_reg;
            end
        end
    end

    // ************************************************
    // interrupt status
    // ************************************************
    assign events[LSUP_STAT_LOSS_BIT] = loss_event_reg;
    assign events[LSUP_STAT_REFRESH_BIT] = refresh_reg;

    // an event in the same cycle as the clearing read survives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg <= '0;
        end else if (ar_take && {s_axi_araddr[7:2], 2'h0} == LSUP_STAT_OFF) begin
            status_reg <= events;
        end else begin
            status_reg <= status_reg | events;
        end
    end

    assign irq = |(status_reg & mask_reg);

    // ************************************************
    // millisecond and communication cycle ticks
    // ************************************************
    assign ms_tick = (ms_cnt_reg == 17'(MS_CYCLES - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn || ms_tick) begin
            ms_cnt_reg <= 17'h00000;
        end else begin
            ms_cnt_reg <= ms_cnt_reg + 17'h00001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cyc_cnt_reg <= 4'h0;
            cycle_tick_reg <= 1'b0;
        end else begin
            cycle_tick_reg <= 1'b0;
            if (ms_tick) begin
                if (cyc_cnt_reg >= (cfg_reg.cycle_speed_select ? LSUP_CYCLE_FAST_MS - 4'h1
                                                               : LSUP_CYCLE_SLOW_MS - 4'h1)) begin
                    cyc_cnt_reg <= 4'h0;
                    cycle_tick_reg <= 1'b1;
                end else begin
                    cyc_cnt_reg <= cyc_cnt_reg + 4'h1;
                end
            end
        end
    end

    assign cycle_tick = cycle_tick_reg;

    // ************************************************
    // silence watch
    // ************************************************
    assign restart = (cfg_reg.mode == LSUP_MODE_ANY && fb.request) ||
                     (cfg_reg.mode == LSUP_MODE_CTRL && fb.ctrl_write);
    assign limit = {8'h00, cfg_reg.timeout} * LSUP_TMO_UNIT_MS;
    // loss fires on the tick that would carry silence past the limit
    assign expiry = sup_state_reg == SUP_WATCH && !restart && ms_tick &&
                    silence_reg >= limit;

    always_ff @(posedge aclk) begin
        if (!aresetn || cfg_reg.mode == LSUP_MODE_OFF) begin
            sup_state_reg <= SUP_OFF;
            silence_reg <= 24'h000000;
        end else begin
            case (sup_state_reg)
                SUP_OFF: begin
                    sup_state_reg <= SUP_WATCH;
                    silence_reg <= 24'h000000;
                end
                SUP_WATCH: begin
                    if (restart) begin
                        silence_reg <= 24'h000000;
                    end else if (expiry) begin
                        sup_state_reg <= SUP_LOST;
                    end else if (ms_tick) begin
                        silence_reg <= silence_reg + 24'h000001;
                    end
                end
                SUP_LOST: begin
                    if (restart) begin
                        sup_state_reg <= SUP_WATCH;
                        silence_reg <= 24'h000000;
                    end
                end
                default: sup_state_reg <= SUP_OFF;
            endcase
        end
    end

    // ************************************************
    // loss actions
    // ************************************************
    // fault holds until software resets it; alarm ends when traffic resumes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loss_event_reg <= 1'b0;
            fault_reg <= 1'b0;
            alarm_reg <= 1'b0;
            avg_hold_reg <= 32'h00000000;
        end else begin
            loss_event_reg <= expiry;
            if (expiry && cfg_reg.action == LSUP_ACT_FAULT) begin
                fault_reg <= 1'b1;
            end else if (do_write && aw_addr_reg == LSUP_CTRL_OFF && w_strb_reg[1] &&
                         w_data_reg[LSUP_CTRL_FRESET_BIT]) begin
                fault_reg <= 1'b0;
            end
            if (expiry && (cfg_reg.action == LSUP_ACT_SAFE ||
                           cfg_reg.action == LSUP_ACT_LAST)) begin
                alarm_reg <= 1'b1;
                avg_hold_reg <= avg_now;
            end else if (sup_state_reg != SUP_LOST) begin
                alarm_reg <= 1'b0;
            end
        end
    end

    assign link_loss_event = loss_event_reg;
    assign fault_trip = fault_reg;
    assign loss_alarm = alarm_reg;

    // ************************************************
    // reference scaling and averaging
    // ************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_reg <= 32'h00000000;
            act_reg <= 32'h00000000;
        end else if (cfg_reg.short_word_profile) begin
            ref_reg <= {16'h0000, fb.ref_word} * {16'h0000, scale_reg};
            act_reg <= {16'h0000, fb.actual} * {16'h0000, scale_reg};
        end else begin
            ref_reg <= {16'h0000, fb.ref_word};
            act_reg <= {16'h0000, fb.actual};
        end
    end

    // sixteen samples spaced evenly over the window; coarse but needs no divider
    assign avg_now = 32'(avg_sum_reg >> LSUP_AVG_SHIFT);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            avg_ms_reg <= 10'h000;
            avg_idx_reg <= 4'h0;
            avg_sum_reg <= 36'h000000000;
            for (int i = 0; i < LSUP_AVG_DEPTH; i++) begin
                avg_ring[i] <= 32'h00000000;
            end
        end else if (ms_tick) begin
            if (avg_ms_reg == LSUP_AVG_SAMPLE_MS - 10'h001) begin
                avg_ms_reg <= 10'h000;
                avg_ring[avg_idx_reg] <= ref_reg;
                avg_sum_reg <= avg_sum_reg - {4'h0, avg_ring[avg_idx_reg]} + {4'h0, ref_reg};
                avg_idx_reg <= avg_idx_reg + 4'h1;
            end else begin
                avg_ms_reg <= avg_ms_reg + 10'h001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            speed_reg <= 32'h00000000;
        end else if (alarm_reg && cfg_reg.action == LSUP_ACT_SAFE) begin
            speed_reg <= safe_reg;
        end else if (alarm_reg && cfg_reg.action == LSUP_ACT_LAST) begin
            speed_reg <= avg_hold_reg;
        end else begin
            speed_reg <= ref_reg;
        end
    end

    assign ref_scaled = ref_reg;
    assign act_scaled = act_reg;
    assign speed_ref = speed_reg;

endmodule

//--- verif/lsup_checker.sv
// checker: bus answers and loss output relations of the supervisor
// assumes a single aclk domain and the synchronous active-low reset
`timescale 1ns/100ps
module lsup_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic fault_trip,
    input wire logic loss_alarm,
    input wire logic link_loss_event,
    input wire logic cycle_tick
);
    // ************************************************
    // properties
    // ************************************************
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_event_pulse: assert property (link_loss_event |=> !link_loss_event)
        else $error("loss event longer than one cycle");
    a_fault_cause: assert property ($rose(fault_trip) |-> link_loss_event)
        else $error("fault without loss event");
    a_alarm_cause: assert property ($rose(loss_alarm) |-> link_loss_event)
        else $error("alarm without loss event");
    // ticks only fall on millisecond boundaries, so never closer than one ms
    a_tick_gap: assert property (cycle_tick |=> !cycle_tick [*8])
        else $error("cycle ticks too close");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
endmodule
bind lsup_supervisor lsup_checker u_lsup_checker (.*);

//--- verif/lsup_fb_master.sv
// partner: fieldbus master issuing requests and reference words
// assumes strobes of one aclk cycle, changed right after a rising edge
`timescale 1ns/100ps
module lsup_fb_master
    import lsup_pkg::*;
(
    input wire logic aclk,
    output lsup_fb_t fb
);
    initial fb = '0;
    task send(input logic wr);
        @(posedge aclk);
        fb.request <= 1'b1;
        fb.ctrl_write <= wr;
        @(posedge aclk);
        fb.request <= 1'b0;
        fb.ctrl_write <= 1'b0;
    endtask
    task set_words(input logic [15:0] r, input logic [15:0] a);
        @(posedge aclk);
        fb.ref_word <= r;
        fb.actual <= a;
    endtask
endmodule

//--- verif/lsup_supervisor_tb_top.sv
// testbench: register and fieldbus sequences against the supervisor
// assumes MS_CYCLES of 10, so one ms is ten clocks
`timescale 1ns/100ps
module lsup_supervisor_tb_top;
    import lsup_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [3:0] wstrb = 4'hF;
    logic [31:0] wdata = 32'h0, rdata, rd, ref_scaled, act_scaled, speed_ref;
    logic [1:0] bresp, rresp, resp;
    logic awready, wready, bvalid, arready, rvalid;
    logic fault_trip, loss_alarm, link_loss_event, cycle_tick, irq;
    lsup_fb_t fb;
    int err_total = 0, check_count = 0, n;
    always #5 aclk = ~aclk;
    lsup_fb_master u_lsup_fb_master (.aclk(aclk), .fb(fb));
    lsup_supervisor #(.MS_CYCLES(10)) u_lsup_supervisor (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .fb(fb), .ref_scaled(ref_scaled), .act_scaled(act_scaled), .speed_ref(speed_ref),
        .fault_trip(fault_trip), .loss_alarm(loss_alarm), .link_loss_event(link_loss_event),
        .cycle_tick(cycle_tick), .irq(irq));
    // ************************************************
    // tasks
    // ************************************************
    task report_and_stop;
        if (err_total == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one access at a time; answer sampled just before the edge that takes it
    task axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic ha, hw, hr;
        @(posedge aclk);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awvalid <= wr;
        wvalid <= wr;
        bready <= wr;
        arvalid <= !wr;
        rready <= !wr;
        for (int i = 0; i < 50; i++) begin
            #1;
            ha = (awvalid && awready) || (arvalid && arready);
            hw = wvalid && wready;
            hr = wr ? bvalid : rvalid;
            rd = rdata;
            resp = wr ? bresp : rresp;
            @(posedge aclk);
            if (ha) begin
                awvalid <= 1'b0;
                arvalid <= 1'b0;
            end
            if (hw)
                wvalid <= 1'b0;
            if (hr) begin
                bready <= 1'b0;
                rready <= 1'b0;
                i = 99;
            end
        end
        #1;
        if (!hr) begin
            err_total++;
            $display("unexpected at %0t: bus wait ran out", $time);
            report_and_stop();
        end
    endtask
    task wait_ev(input int lim);
        for (n = 0; n < lim; n++) begin
            @(posedge aclk);
            #1;
            if (link_loss_event === 1'b1)
                return;
        end
    endtask
    task tick_gap;
        for (n = 0; n < 200 && cycle_tick !== 1'b1; n++)
            @(posedge aclk) #1;
        for (n = 1; n < 200; n++) begin
            @(posedge aclk);
            #1;
            if (cycle_tick === 1'b1)
                return;
        end
    endtask
    // ************************************************
    // sequence
    // ************************************************
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        axi(1'b0, LSUP_TMO_OFF, 32'h0);
        chk(rd, 32'hA);
        axi(1'b0, 8'h1C, 32'h0);
        chk(32'(resp), 32'(LSUP_RESP_SLVERR));
        axi(1'b1, 8'h1C, 32'h0);
        chk(32'(resp), 32'(LSUP_RESP_SLVERR));
        axi(1'b1, LSUP_MASK_OFF, 32'h1);
        axi(1'b1, LSUP_TMO_OFF, 32'h1);
        axi(1'b1, LSUP_CTRL_OFF, 32'h100);
        axi(1'b0, LSUP_CTRL_OFF, 32'h0);
        chk(32'(rd[8]), 32'h0);
        axi(1'b0, LSUP_STAT_OFF, 32'h0);
        chk(32'(rd[1:0]), 32'h2);
        wait_ev(1500);
        chk(n, 1500);
        axi(1'b1, LSUP_CTRL_OFF, 32'h105);
        for (int k = 0; k < 4; k++) begin
            wait_ev(500);
            chk(n, 500);
            u_lsup_fb_master.send(1'b0);
        end
        wait_ev(1100);
        chk(32'(n >= 990 && n <= 1030), 32'h1);
        chk(32'(fault_trip), 32'h1);
        #10 chk(32'(irq), 32'h1);
        axi(1'b1, LSUP_MASK_OFF, 32'h0);
        chk(32'(irq), 32'h0);
        axi(1'b0, LSUP_STAT_OFF, 32'h0);
        chk(32'(rd[0]), 32'h1);
        axi(1'b1, LSUP_CTRL_OFF, 32'h205);
        chk(32'(fault_trip), 32'h0);
        axi(1'b1, LSUP_SAFE_OFF, 32'h1234);
        axi(1'b1, LSUP_CTRL_OFF, 32'h10A);
        u_lsup_fb_master.send(1'b1);
        for (int k = 0; k < 3; k++) begin
            wait_ev(300);
            chk(n, 300);
            u_lsup_fb_master.send(1'b0);
        end
        wait_ev(200);
        chk(32'(n < 150), 32'h1);
        chk({loss_alarm, fault_trip}, 32'h2);
        repeat (3) @(posedge aclk);
        chk(speed_ref, 32'h1234);
        u_lsup_fb_master.send(1'b1);
        repeat (4) @(posedge aclk);
        chk(32'(loss_alarm), 32'h0);
        axi(1'b1, LSUP_CTRL_OFF, 32'h10E);
        u_lsup_fb_master.send(1'b1);
        u_lsup_fb_master.set_words(16'h0050, 16'h0007);
        wait_ev(1100);
        chk(32'(loss_alarm), 32'h1);
        repeat (3) @(posedge aclk);
        chk(32'(speed_ref < ref_scaled), 32'h1);
        wstrb <= 4'h1;
        axi(1'b1, LSUP_SCALE_OFF, 32'h503);
        wstrb <= 4'hF;
        axi(1'b1, LSUP_SCALE_OFF, 32'h0);
        axi(1'b0, LSUP_SCALE_OFF, 32'h0);
        chk(rd, 32'h3);
        axi(1'b1, LSUP_CTRL_OFF, 32'h30);
        chk(ref_scaled, 32'h50);
        tick_gap();
        chk(n, 100);
        axi(1'b1, LSUP_CTRL_OFF, 32'h130);
        repeat (3) @(posedge aclk);
        chk(ref_scaled, 32'hF0);
        chk(act_scaled, 32'h15);
        tick_gap();
        tick_gap();
        chk(n, 20);
        report_and_stop();
    end
endmodule
